// File: rtl/ict_sequencer.sv
module ict_sequencer (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire ict_pkg::ict_instr_type instr,
    input wire logic [1:0] flash_read_wait_setting,
    output logic instr_ready,
    output logic busy,
    output logic done,
    output ict_pkg::ict_result_type result
);

    // ------------------------------------------------------------
    // Duration lookup
    // ------------------------------------------------------------
    typedef enum logic {
        ICT_IDLE,
        ICT_EXEC
    } ict_state_type;

    ict_state_type state;
    logic [3:0] remaining;
    logic [3:0] next_total;
    logic [3:0] total;
    logic [1:0] held_bytes;
    logic [3:0] code_extra;
    logic [1:0] wait_clamped;
    logic accept;
    logic finishing;

    always_comb begin
        // Extra wait states limited so the read never exceeds its range
        wait_clamped = flash_read_wait_setting;
        if (flash_read_wait_setting == ict_pkg::ICT_WAIT_MAX) begin
            wait_clamped = ict_pkg::ICT_WAIT_W;
        end
        code_extra = {2'h0, wait_clamped} + {3'h0, instr.misaligned};
    end

    always_comb begin
        next_total = {2'h0, instr.bytes};
        case (instr.cls)
            ict_pkg::ICT_ACC_REG: next_total = ict_pkg::ICT_CYC_1;
            ict_pkg::ICT_ACC_DIRECT: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_ACC_INDIRECT: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_ACC_IMM: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_DIRECT_IMM: next_total = ict_pkg::ICT_CYC_3;
            ict_pkg::ICT_DIRECT_DIRECT: next_total = ict_pkg::ICT_CYC_3;
            ict_pkg::ICT_PTR_INC: next_total = ict_pkg::ICT_CYC_1;
            ict_pkg::ICT_PTR_LOAD: next_total = ict_pkg::ICT_CYC_3;
            ict_pkg::ICT_CODE_READ_PTR: begin
                next_total = ict_pkg::ICT_CYC_CODE_MIN + code_extra;
                if (next_total > ict_pkg::ICT_CYC_CODE_MAX) begin
                    next_total = ict_pkg::ICT_CYC_CODE_MAX;
                end
            end
            ict_pkg::ICT_CODE_READ_PC: next_total = ict_pkg::ICT_CYC_3;
            ict_pkg::ICT_EXT_XFER: next_total = ict_pkg::ICT_CYC_3;
            ict_pkg::ICT_STACK: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_NIBBLE_SWAP: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_ROTATE: next_total = ict_pkg::ICT_CYC_1;
            ict_pkg::ICT_IND_IMM: next_total = ict_pkg::ICT_CYC_2;
            ict_pkg::ICT_PRODUCT: next_total = ict_pkg::ICT_CYC_4;
            ict_pkg::ICT_DIVIDE: next_total = ict_pkg::ICT_CYC_DIVIDE;
            ict_pkg::ICT_COND_BRANCH: begin
                // Taken costs one more than the untaken byte count
                next_total = {2'h0, instr.bytes}
                    + (instr.taken ? ict_pkg::ICT_CYC_BRANCH_TAKEN
                                   : ict_pkg::ICT_CYC_ZERO);
            end
            default: next_total = {2'h0, instr.bytes};
        endcase
        if (next_total > ict_pkg::ICT_CYC_MAX) begin
            next_total = ict_pkg::ICT_CYC_MAX;
        end
        if (next_total == ict_pkg::ICT_CYC_ZERO) begin
            next_total = ict_pkg::ICT_CYC_ONE;
        end
    end

    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    // The accepting edge only loads the count; cycle one is the cycle after it,
    // so single-cycle instructions finish on the following edge.
    assign finishing = (state == ICT_EXEC) && (remaining == ict_pkg::ICT_CYC_ONE);
    assign accept = instr_valid && ((state == ICT_IDLE) || finishing);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ICT_IDLE;
            remaining <= ict_pkg::ICT_CYC_ZERO;
            total <= ict_pkg::ICT_CYC_ZERO;
            held_bytes <= ict_pkg::ICT_WAIT_ZERO;
        end else if (accept) begin
            // Whole design counts raw clock edges only
            state <= ICT_EXEC;
            remaining <= next_total;
            total <= next_total;
            held_bytes <= instr.bytes;
        end else begin
            case (state)
                ICT_IDLE: state <= ICT_IDLE;
                ICT_EXEC: begin
                    if (finishing) begin
                        state <= ICT_IDLE;
                    end
                    remaining <= remaining - ict_pkg::ICT_CYC_ONE;
                end
                default: state <= ICT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Ready is registered, so it is computed for the coming cycle.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_ready <= 1'b0;
            busy <= 1'b0;
        end else begin
            instr_ready <= accept ? (next_total == ict_pkg::ICT_CYC_ONE)
                : ((state == ICT_IDLE) || finishing
                   || (remaining == ict_pkg::ICT_CYC_2));
            busy <= accept ? 1'b1 : ((state == ICT_EXEC) && !finishing);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            done <= 1'b0;
            result <= '0;
        end else begin
            done <= finishing;
            if (finishing) begin
                result.cycles <= total;
                result.bytes <= held_bytes;
            end
        end
    end

endmodule

// File: shared/ict_pkg.sv
package ict_pkg;

    // ------------------------------------------------------------
    // Instruction classes as decoded by the fetch stage
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ICT_ACC_REG,      // Accumulator with bank_work_reg
        ICT_ACC_DIRECT,   // Accumulator with direct byte
        ICT_ACC_INDIRECT, // Through bank_pointer_reg
        ICT_ACC_IMM,      // Immediate, incl. borrow_subtract_op
        ICT_DIRECT_IMM,   // Immediate with direct byte
        ICT_DIRECT_DIRECT,
        ICT_PTR_INC,
        ICT_PTR_LOAD,
        ICT_CODE_READ_PTR,
        ICT_CODE_READ_PC,
        ICT_EXT_XFER,
        ICT_STACK,
        ICT_NIBBLE_SWAP,
        ICT_ROTATE,
        ICT_IND_IMM,
        ICT_PRODUCT,
        ICT_DIVIDE,
        ICT_COND_BRANCH,
        ICT_GENERIC       // Timing equals byte count
    } ict_class_type;

    typedef struct packed {
        ict_class_type cls;
        logic [1:0] bytes;    // Length in program bytes, 1..3
        logic taken;          // Branch outcome, conditional branch only
        logic misaligned;     // Operand fetch straddles a flash line
    } ict_instr_type;

    typedef struct packed {
        logic [3:0] cycles;   // Cycles the finished instruction took
        logic [1:0] bytes;
    } ict_result_type;

    // ------------------------------------------------------------
    // Cycle counts, byte count and wait-state values
    // ------------------------------------------------------------
    localparam logic [3:0] ICT_CYC_1 = 4'h1;
    localparam logic [3:0] ICT_CYC_2 = 4'h2;
    localparam logic [3:0] ICT_CYC_3 = 4'h3;
    localparam logic [3:0] ICT_CYC_4 = 4'h4;
    localparam logic [3:0] ICT_CYC_CODE_MIN = 4'h4;
    localparam logic [3:0] ICT_CYC_CODE_MAX = 4'h7;
    localparam logic [3:0] ICT_CYC_DIVIDE = 4'h8;
    localparam logic [3:0] ICT_CYC_MAX = 4'h8;
    localparam logic [3:0] ICT_CYC_BRANCH_TAKEN = 4'h1;
    localparam logic [3:0] ICT_CYC_ZERO = 4'h0;
    localparam logic [3:0] ICT_CYC_ONE = 4'h1;
    localparam logic [1:0] ICT_BYTES_ONE = 2'h1;
    localparam logic [1:0] ICT_WAIT_W = 2'h2;
    localparam logic [1:0] ICT_WAIT_ZERO = 2'h0;
    localparam logic [1:0] ICT_WAIT_MAX = 2'h3;

endpackage

// File: verif/ict_fetch_model.sv
module ict_fetch_model (
    input wire logic offer,
    input wire ict_pkg::ict_instr_type want,
    output logic instr_valid,
    output ict_pkg::ict_instr_type instr
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle operand lines show the inverse, so a stale value never passes
    assign instr_valid = offer;
    assign instr = offer ? want : ~want;
endmodule

// File: verif/ict_properties.sv
module ict_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire ict_pkg::ict_instr_type instr,
    input wire logic [1:0] flash_read_wait_setting,
    input wire logic instr_ready,
    input wire logic busy,
    input wire logic done,
    input wire ict_pkg::ict_result_type result
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic take;
    assign take = instr_valid && instr_ready;
    cyc_bound_a: assert property (
        done |-> result.cycles inside {[1:8]}) else $error("too long");
    one_cycle_a: assert property (
        take && instr.cls inside {ict_pkg::ICT_ACC_REG, ict_pkg::ICT_PTR_INC,
        ict_pkg::ICT_ROTATE} |-> ##2 done && result.cycles == 4'h1)
        else $error("one cycle class late");
    two_cycle_a: assert property (
        take && instr.cls inside {ict_pkg::ICT_ACC_INDIRECT,
        ict_pkg::ICT_ACC_IMM, ict_pkg::ICT_STACK, ict_pkg::ICT_NIBBLE_SWAP,
        ict_pkg::ICT_IND_IMM} |-> ##2 !done ##1 done && result.cycles == 4'h2)
        else $error("two cycle class wrong");
    three_cycle_a: assert property (
        take && instr.cls inside {ict_pkg::ICT_DIRECT_IMM,
        ict_pkg::ICT_DIRECT_DIRECT, ict_pkg::ICT_PTR_LOAD,
        ict_pkg::ICT_CODE_READ_PC, ict_pkg::ICT_EXT_XFER}
        |-> ##2 !done [*2] ##1 done && result.cycles == 4'h3)
        else $error("three cycle class wrong");
    product_len_a: assert property (
        take && instr.cls == ict_pkg::ICT_PRODUCT
        |-> ##5 done && result.cycles == 4'h4) else $error("product wrong");
    divide_len_a: assert property (
        take && instr.cls == ict_pkg::ICT_DIVIDE
        |-> ##9 done && result.cycles == 4'h8) else $error("divide wrong");
    code_read_a: assert property (
        take && instr.cls == ict_pkg::ICT_CODE_READ_PTR
        |-> ##[5:8] done && result.cycles inside {[4:7]})
        else $error("code read out of range");
    result_hold_a: assert property (
        !done |-> $stable(result)) else $error("result moved");
endmodule

// File: verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic offer = 1'b0;
    logic [1:0] flash_read_wait_setting = 2'h0;
    ict_pkg::ict_instr_type want = '0;
    logic instr_valid, instr_ready, busy, done;
    ict_pkg::ict_instr_type instr;
    ict_pkg::ict_result_type result;
    int num_errors = 0;
    int checks_done = 0;
    always #2 mclk = ~mclk;
    ict_fetch_model ict_fetch_model_inst (.offer(offer), .want(want),
        .instr_valid(instr_valid), .instr(instr));
    ict_sequencer ict_sequencer_inst (.mclk(mclk), .sys_rst(sys_rst),
        .instr_valid(instr_valid), .instr(instr),
        .flash_read_wait_setting(flash_read_wait_setting),
        .instr_ready(instr_ready), .busy(busy), .done(done), .result(result));
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic ict_pkg::ict_instr_type mk(
        input ict_pkg::ict_class_type c, input logic [1:0] b,
        input logic tk, input logic m);
        return '{c, b, tk, m};
    endfunction
    // Leaves the offer up so a caller can queue the next instruction
    task automatic send(input ict_pkg::ict_instr_type ins);
        int n;
        n = 0;
        want = ins;
        offer = 1'b1;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic finish(input ict_pkg::ict_instr_type ins,
        input logic [3:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 12);
        chk(8'(n), {4'h0, exp});
        chk({4'h0, result.cycles}, {4'h0, exp});
        chk({6'h0, result.bytes}, {6'h0, ins.bytes});
    endtask
    task automatic issue(input ict_pkg::ict_instr_type ins,
        input logic [3:0] exp);
        send(ins);
        offer = 1'b0;
        chk({7'h0, busy}, 8'h01);
        chk({7'h0, instr_ready}, {7'h0, exp == 4'h1});
        finish(ins, exp);
        chk({7'h0, busy}, 8'h00);
    endtask
    task automatic t_fixed();
        logic [3:0] cyc [17];
        logic [1:0] len [17];
        cyc = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h1, 4'h3, 4'h4, 4'h3,
            4'h3, 4'h2, 4'h2, 4'h1, 4'h2, 4'h4, 4'h8};
        len = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3, 2'h1, 2'h1,
            2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
        for (int i = 0; i < 17; i++) begin
            issue(mk(ict_pkg::ict_class_type'(i), len[i], 1'b0, 1'b0),
                cyc[i]);
        end
    endtask
    task automatic t_code_read();
        for (int w = 0; w < 4; w++) begin
            for (int m = 0; m < 2; m++) begin
                flash_read_wait_setting = 2'(w);
                issue(mk(ict_pkg::ICT_CODE_READ_PTR, 2'h1, 1'b0, 1'(m)),
                    4'(4 + (w > 2 ? 2 : w) + m));
            end
        end
        flash_read_wait_setting = 2'h0;
    endtask
    task automatic t_branch();
        for (int t = 0; t < 2; t++) begin
            issue(mk(ict_pkg::ICT_COND_BRANCH, 2'h2, 1'(t), 1'b0),
                4'(2 + t));
        end
        for (int b = 0; b < 4; b++) begin
            issue(mk(ict_pkg::ICT_GENERIC, 2'(b), 1'b0, 1'b0),
                4'(b == 0 ? 1 : b));
        end
    endtask
    // Offer held through a divide: refused until its last cycle
    task automatic t_overlap();
        send(mk(ict_pkg::ICT_DIVIDE, 2'h1, 1'b0, 1'b0));
        want = mk(ict_pkg::ICT_EXT_XFER, 2'h1, 1'b0, 1'b0);
        finish(mk(ict_pkg::ICT_DIVIDE, 2'h1, 1'b0, 1'b0), 4'h8);
        offer = 1'b0;
        chk({7'h0, busy}, 8'h01);
        chk({7'h0, instr_ready}, 8'h00);
        finish(want, 4'h3);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #40000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        @(posedge mclk);
        #1;
        t_fixed();
        t_code_read();
        t_branch();
        t_overlap();
        conclude();
    end
endmodule
bind ict_sequencer ict_checker ict_checker_inst (.mclk(mclk),
    .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .flash_read_wait_setting(flash_read_wait_setting),
    .instr_ready(instr_ready), .busy(busy), .done(done), .result(result));
